//--- design/pscs_sequencer.sv
// Functional notes
// - Out of reset the sequencer sits in pre-active on both RC oscillators.
// - Pre-active is entered from reset, standby or sleep and leads only on.
// - Active is entered only from pre-active.
// - Active runs on the high-speed crystal with the 16MHz RC switched off.
// - Radio transmit or receive is allowed only in active.
// - Standby comes only from active, keeps 12 or 24kB, exits to pre-active.
// - Five wake pins are accepted; three pulled up, two driven externally.
// - Standby resume takes about 200us before running again.
// - Sleep comes only from active, keeps RAM and the low-speed oscillator.
// - Sleep honours the same five wake pins and exits via pre-active.
// - The 16MHz RC supplies high speed while the crystal starts up.
// - Radio is refused unless a 16 or 32MHz crystal is running.
// - With 32MHz crystal the core runs 32MHz, the peripherals 16MHz.
// - With 16MHz crystal core and all the clock tree run at 16MHz.
// - Sleep uses the low-speed clock from RC or 32kHz crystal; standby stops both.
`timescale 1ns/1ps
module pscs_sequencer (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Supplies and oscillators
  input wire logic supplies_ok,
  input wire logic hs_xtal_ready,
  input wire logic hs_xtal_32m,
  input wire logic ls_xtal_sel,
  // Software requests
  input wire logic req_standby,
  input wire logic req_sleep,
  input wire logic ret_24k,
  input wire logic radio_req,
  // Wake pins
  input wire logic wake_pin_a,
  input wire logic wake_pin_b,
  input wire logic wake_pin_c,
  input wire logic wake_pin_d,
  input wire logic wake_pin_e,
  // Status and controls
  output pscs_pkg::pscs_state_t state,
  output logic rc16_en,
  output logic hs_xtal_en,
  output logic ls_rc_en,
  output logic ls_xtal_en,
  output logic ram_ret_24k,
  output logic radio_en,
  output logic [1:0] core_freq,
  output logic [1:0] periph_freq,
  output logic wake_pullup_en,
  output logic running
);
  import pscs_pkg::*;

  // ----------------------------------------------------------------------
  // Wake pin synchronisers
  // ----------------------------------------------------------------------
  logic [4:0] wake_raw;
  logic [4:0] wake_s;
  // Driven pins inverted first so all flops idle high out of reset
  assign wake_raw = {~wake_pin_e, ~wake_pin_d, wake_pin_c, wake_pin_b,
                     wake_pin_a};

  // Pins a..c idle high on pull-ups; d and e driven by sensors
  genvar gi;
  generate
    for (gi = 0; gi < PSCS_NUM_WAKE; gi++) begin : g_sync
      pscs_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d(wake_raw[gi]),
        .q(wake_s[gi])
      );
    end
  endgenerate

  // Any low synchronised level is a wake
  logic wake_any;
  assign wake_any = ~&wake_s;

  // ----------------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------------
  pscs_state_t state_r;
  pscs_state_t state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic ret_r;
  logic ret_nxt;
  logic running_r;
  logic running_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ret_nxt = ret_r;
    running_nxt = running_r;
    unique case (state_r)
      PSCS_PREACTIVE: begin
        // Only way out is active, once the crystal is stable
        if (cnt_r != 16'h0000) begin
          cnt_nxt = cnt_r - 16'h0001;
        end else if (supplies_ok && hs_xtal_ready) begin
          state_nxt = PSCS_ACTIVE;
          running_nxt = 1'b1;
        end
      end
      PSCS_ACTIVE: begin
        // Standby wins when both are asked in the same cycle
        if (req_standby) begin
          state_nxt = PSCS_STANDBY;
          ret_nxt = ret_24k;
          running_nxt = 1'b0;
        end else if (req_sleep) begin
          state_nxt = PSCS_SLEEP;
          ret_nxt = ret_24k;
          running_nxt = 1'b0;
        end
      end
      PSCS_STANDBY: begin
        if (wake_any) begin
          state_nxt = PSCS_PREACTIVE;
          cnt_nxt = PSCS_WAKE_CYCLES[15:0] - 16'h0001;
        end
      end
      PSCS_SLEEP: begin
        if (wake_any) begin
          state_nxt = PSCS_PREACTIVE;
        end
      end
      default: begin
        state_nxt = PSCS_PREACTIVE;
        running_nxt = 1'b0;
      end
    endcase
  end

  // Reset lands in pre-active on RC oscillators
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PSCS_PREACTIVE;
      cnt_r <= PSCS_CNT_RST;
      ret_r <= PSCS_RET_24K;
      running_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ret_r <= ret_nxt;
      running_r <= running_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Clock and radio controls
  // ----------------------------------------------------------------------
  logic rc16_nxt;
  logic rc16_r;
  logic hsx_nxt;
  logic hsx_r;
  logic lsrc_nxt;
  logic lsrc_r;
  logic lsx_nxt;
  logic lsx_r;
  logic radio_nxt;
  logic radio_r;
  logic [1:0] core_nxt;
  logic [1:0] core_r;
  logic [1:0] per_nxt;
  logic [1:0] per_r;
  logic pullup_nxt;
  logic pullup_r;

  always_comb begin
    rc16_nxt = 1'b0;
    hsx_nxt = 1'b0;
    lsrc_nxt = ~ls_xtal_sel;
    lsx_nxt = ls_xtal_sel;
    radio_nxt = 1'b0;
    core_nxt = PSCS_FREQ_OFF;
    per_nxt = PSCS_FREQ_OFF;
    pullup_nxt = 1'b1;
    unique case (state_nxt)
      PSCS_PREACTIVE: begin
        // RC carries the core while the crystal starts
        rc16_nxt = 1'b1;
        hsx_nxt = 1'b1;
        lsrc_nxt = 1'b1;
        core_nxt = PSCS_FREQ_16M;
        per_nxt = PSCS_FREQ_16M;
      end
      PSCS_ACTIVE: begin
        rc16_nxt = 1'b0;
        hsx_nxt = 1'b1;
        radio_nxt = radio_req && hs_xtal_ready;
        if (hs_xtal_32m) begin
          core_nxt = PSCS_FREQ_32M;
          per_nxt = PSCS_FREQ_16M;
        end else begin
          core_nxt = PSCS_FREQ_16M;
          per_nxt = PSCS_FREQ_16M;
        end
      end
      PSCS_STANDBY: begin
        lsrc_nxt = 1'b0;
        lsx_nxt = 1'b0;
      end
      PSCS_SLEEP: begin
        // Low-speed clock kept for periodic connection events
        lsrc_nxt = ~ls_xtal_sel;
        lsx_nxt = ls_xtal_sel;
      end
      default: begin
        rc16_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rc16_r <= 1'b1;
      hsx_r <= 1'b1;
      lsrc_r <= 1'b1;
      lsx_r <= 1'b0;
      radio_r <= 1'b0;
      core_r <= PSCS_FREQ_16M;
      per_r <= PSCS_FREQ_16M;
      pullup_r <= 1'b1;
    end else begin
      rc16_r <= rc16_nxt;
      hsx_r <= hsx_nxt;
      lsrc_r <= lsrc_nxt;
      lsx_r <= lsx_nxt;
      radio_r <= radio_nxt;
      core_r <= core_nxt;
      per_r <= per_nxt;
      pullup_r <= pullup_nxt;
    end
  end

  assign state = state_r;
  assign rc16_en = rc16_r;
  assign hs_xtal_en = hsx_r;
  assign ls_rc_en = lsrc_r;
  assign ls_xtal_en = lsx_r;
  assign ram_ret_24k = ret_r;
  assign radio_en = radio_r;
  assign core_freq = core_r;
  assign periph_freq = per_r;
  assign wake_pullup_en = pullup_r;
  assign running = running_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_active_entry: assert property (@(posedge mclk) disable iff (!rst_n)
    state_r == PSCS_ACTIVE && $past(state_r) != PSCS_ACTIVE
    |-> $past(state_r) == PSCS_PREACTIVE)
    else $error("active entered not from pre-active");
  a_standby_entry: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(state_r == PSCS_STANDBY) |-> $past(state_r) == PSCS_ACTIVE)
    else $error("standby entered not from active");
  a_sleep_entry: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(state_r == PSCS_SLEEP) |-> $past(state_r) == PSCS_ACTIVE)
    else $error("sleep entered not from active");
  a_preactive_exit: assert property (@(posedge mclk) disable iff (!rst_n)
    state_r == PSCS_PREACTIVE ##1 state_r != PSCS_PREACTIVE
    |-> state_r == PSCS_ACTIVE)
    else $error("pre-active left toward other than active");
  a_radio_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    radio_en |-> state_r == PSCS_ACTIVE && hs_xtal_en && !rc16_en)
    else $error("radio on outside active");
  a_radio_xtal: assert property (@(posedge mclk) disable iff (!rst_n)
    radio_en |-> $past(hs_xtal_ready))
    else $error("radio on without running crystal");
  a_freq_32m: assert property (@(posedge mclk) disable iff (!rst_n)
    state_r == PSCS_ACTIVE && $past(hs_xtal_32m) && $past(state_r) ==
    PSCS_ACTIVE |-> core_freq == PSCS_FREQ_32M && periph_freq ==
    PSCS_FREQ_16M)
    else $error("32MHz crystal clock split wrong");
  a_standby_wake: assert property (@(posedge mclk) disable iff (!rst_n)
    state_r == PSCS_STANDBY && wake_any |=> state_r == PSCS_PREACTIVE
    ##1 (state_r == PSCS_PREACTIVE) [*8])
    else $error("standby wake did not hold pre-active");
  a_sleep_wake: assert property (@(posedge mclk) disable iff (!rst_n)
    state_r == PSCS_SLEEP && wake_any |=> state_r == PSCS_PREACTIVE &&
    rc16_en)
    else $error("sleep wake did not restart oscillators");
endmodule

//--- design/pscs_sync.sv
`timescale 1ns/1ps
module pscs_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Data
  input wire logic d,
  output logic q
);
  import pscs_pkg::*;

  logic meta_r;
  logic meta_nxt;
  logic q_r;
  logic q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  // Reset value is idle high, matching a pulled-up pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b1;
      q_r <= 1'b1;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule

//--- inc/pscs_pkg.sv
package pscs_pkg;

  // ----------------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    PSCS_PREACTIVE = 4'b0001,
    PSCS_ACTIVE    = 4'b0010,
    PSCS_STANDBY   = 4'b0100,
    PSCS_SLEEP     = 4'b1000
  } pscs_state_t;

  // ----------------------------------------------------------------------
  // Clock figures
  // ----------------------------------------------------------------------
  localparam int PSCS_MCLK_MHZ = 100;
  localparam int PSCS_WAKE_TIME_US = 200;
  localparam int PSCS_WAKE_CYCLES = PSCS_WAKE_TIME_US * PSCS_MCLK_MHZ;
  localparam int PSCS_WAKE_CNT_W = 16;
  localparam int PSCS_NUM_WAKE = 5;
  localparam int PSCS_NUM_PULLUP = 3;
  localparam logic [1:0] PSCS_FREQ_16M = 2'h1;
  localparam logic [1:0] PSCS_FREQ_32M = 2'h2;
  localparam logic [1:0] PSCS_FREQ_OFF = 2'h0;
  localparam logic PSCS_RET_24K = 1'b1;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] PSCS_CNT_RST = 16'h0000;
  localparam logic [4:0] PSCS_WAKE_RST = 5'h1f;

endpackage

//--- verif/pscs_wake_model.sv
`timescale 1ns/1ps
module pscs_wake_model (
  // Board events
  input wire logic btn_press,
  input wire logic mag_irq,
  input wire logic imu_irq,
  // Wake pins
  output logic wake_pin_a,
  output logic wake_pin_b,
  output logic wake_pin_c,
  output logic wake_pin_d,
  output logic wake_pin_e
);
  // ------------------------------------------------------------
  // Pin levels
  // ------------------------------------------------------------
  // Unwired pins rest at the pull-up level
  assign wake_pin_a = 1'b1;
  assign wake_pin_b = 1'b1;
  // Button grounds its pulled-up pin
  assign wake_pin_c = ~btn_press;
  // Push-pull interrupts, active high
  assign wake_pin_d = mag_irq;
  assign wake_pin_e = imu_irq;
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pscs_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic mclk = 1'b0, rst_n = 1'b0, supplies_ok = 1'b0;
  logic hs_xtal_ready = 1'b0, hs_xtal_32m = 1'b1, ls_xtal_sel = 1'b0;
  logic req_standby = 1'b0, req_sleep = 1'b0, ret_24k = 1'b1;
  logic radio_req = 1'b0, btn_press = 1'b0, mag_irq = 1'b0;
  logic imu_irq = 1'b0;
  logic wake_pin_a, wake_pin_b, wake_pin_c, wake_pin_d, wake_pin_e;
  pscs_state_t state;
  logic rc16_en, hs_xtal_en, ls_rc_en, ls_xtal_en, ram_ret_24k;
  logic radio_en, wake_pullup_en, running;
  logic [1:0] core_freq, periph_freq;
  int mismatches = 0, checks_done = 0, wait_n = 0;

  initial begin
    forever #5 mclk = ~mclk;
  end

  pscs_wake_model pscs_wake_model_inst (.btn_press, .mag_irq, .imu_irq,
    .wake_pin_a, .wake_pin_b, .wake_pin_c, .wake_pin_d, .wake_pin_e);

  pscs_sequencer pscs_sequencer_inst (.mclk, .rst_n, .supplies_ok,
    .hs_xtal_ready, .hs_xtal_32m, .ls_xtal_sel, .req_standby, .req_sleep,
    .ret_24k, .radio_req, .wake_pin_a, .wake_pin_b, .wake_pin_c,
    .wake_pin_d, .wake_pin_e, .state, .rc16_en, .hs_xtal_en, .ls_rc_en,
    .ls_xtal_en, .ram_ret_24k, .radio_en, .core_freq, .periph_freq,
    .wake_pullup_en, .running);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_v(input string nm, input logic [3:0] exp,
                       input logic [3:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  // Bounded so a stuck state ends the run
  task automatic wait_st(input pscs_state_t tgt, input int lim);
    int n;
    n = 0;
    while (state !== tgt && n < lim) begin
      tick(1);
      n++;
    end
    wait_n = n;
    if (state !== tgt) begin
      mismatches++;
      $display("mismatch wait_state expected %h seen %h", tgt, state);
      final_report();
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_boot();
    chk_v("state", PSCS_PREACTIVE, state);
    chk_v("rc16_en", 1, rc16_en);
    chk_v("ls_rc_en", 1, ls_rc_en);
    chk_v("wake_pullup_en", 1, wake_pullup_en);
    @(posedge mclk);
    radio_req <= 1'b1;
    req_sleep <= 1'b1;
    hs_xtal_ready <= 1'b1;
    tick(6);
    chk_v("state", PSCS_PREACTIVE, state);
    chk_v("radio_en", 0, radio_en);
    @(posedge mclk);
    req_sleep <= 1'b0;
    supplies_ok <= 1'b1;
    wait_st(PSCS_ACTIVE, 50);
    chk_v("rc16_en", 0, rc16_en);
    chk_v("running", 1, running);
    chk_v("hs_xtal_en", 1, hs_xtal_en);
    chk_v("core_freq", PSCS_FREQ_32M, core_freq);
    chk_v("periph_freq", PSCS_FREQ_16M, periph_freq);
    tick(2);
    chk_v("radio_en", 1, radio_en);
    @(posedge mclk);
    hs_xtal_ready <= 1'b0;
    tick(3);
    chk_v("radio_en", 0, radio_en);
    @(posedge mclk);
    hs_xtal_ready <= 1'b1;
    radio_req <= 1'b0;
    $display("test boot done");
  endtask

  task automatic t_standby();
    @(posedge mclk);
    ret_24k <= 1'b0;
    req_standby <= 1'b1;
    req_sleep <= 1'b1;
    @(posedge mclk);
    req_standby <= 1'b0;
    req_sleep <= 1'b0;
    wait_st(PSCS_STANDBY, 10);
    chk_v("ram_ret_24k", 0, ram_ret_24k);
    chk_v("running", 0, running);
    @(posedge mclk);
    btn_press <= 1'b1;
    wait_st(PSCS_PREACTIVE, 10);
    chk_v("rc16_en", 1, rc16_en);
    chk_v("hs_xtal_en", 1, hs_xtal_en);
    chk_v("core_freq", PSCS_FREQ_16M, core_freq);
    @(posedge mclk);
    btn_press <= 1'b0;
    wait_st(PSCS_ACTIVE, 30000);
    chk_v("wake_time", 1, 4'(wait_n >= PSCS_WAKE_CYCLES - 2));
    chk_v("wake_time_max", 1, 4'(wait_n <= PSCS_WAKE_CYCLES + 2));
    $display("test standby done");
  endtask

  // Sleep round trip; low-speed source and wake pin vary per pass
  task automatic t_sleep(input logic xsel, input logic use_imu);
    @(posedge mclk);
    hs_xtal_32m <= 1'b0;
    ls_xtal_sel <= xsel;
    ret_24k <= 1'b1;
    req_sleep <= 1'b1;
    @(posedge mclk);
    req_sleep <= 1'b0;
    wait_st(PSCS_SLEEP, 10);
    chk_v("ram_ret_24k", 1, ram_ret_24k);
    chk_v("ls_xtal_en", 4'(xsel), ls_xtal_en);
    chk_v("ls_rc_en", 4'(!xsel), ls_rc_en);
    @(posedge mclk);
    mag_irq <= !use_imu;
    imu_irq <= use_imu;
    wait_st(PSCS_PREACTIVE, 10);
    @(posedge mclk);
    mag_irq <= 1'b0;
    imu_irq <= 1'b0;
    wait_st(PSCS_ACTIVE, 50);
    chk_v("core_freq", PSCS_FREQ_16M, core_freq);
    chk_v("periph_freq", PSCS_FREQ_16M, periph_freq);
    $display("test sleep done");
  endtask

  // Mid-run reset from active lands back in pre-active
  task automatic t_reset();
    @(posedge mclk);
    radio_req <= 1'b1;
    rst_n <= 1'b0;
    tick(2);
    chk_v("state", PSCS_PREACTIVE, state);
    chk_v("rc16_en", 1, rc16_en);
    chk_v("ls_rc_en", 1, ls_rc_en);
    chk_v("radio_en", 0, radio_en);
    chk_v("running", 0, running);
    @(posedge mclk);
    rst_n <= 1'b1;
    wait_st(PSCS_ACTIVE, 10);
    chk_v("running", 1, running);
    tick(1);
    chk_v("radio_en", 1, radio_en);
    @(posedge mclk);
    radio_req <= 1'b0;
    $display("test reset done");
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    tick(1);
    t_boot();
    t_standby();
    t_sleep(1'b1, 1'b0);
    t_sleep(1'b0, 1'b1);
    t_reset();
    final_report();
  end
endmodule
